// ### inc/ums_pkg.sv
// package for the modem status, baud generator and receiver block
package ums_pkg;
  localparam logic [7:0] ADDR_RXBUF_DLL = 8'h00;
  localparam logic [7:0] ADDR_IER_DLM = 8'h04;
  localparam logic [7:0] ADDR_FCR = 8'h08;
  localparam logic [7:0] ADDR_LCR = 8'h0c;
  localparam logic [7:0] ADDR_MCR = 8'h10;
  localparam logic [7:0] ADDR_LSR = 8'h14;
  localparam logic [7:0] ADDR_MSR = 8'h18;
  localparam logic [7:0] ADDR_SCR = 8'h1c;
  localparam logic [7:0] ADDR_IRQ = 8'h20;
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_AUX_OUTPUT_ONE = 2;
  localparam int MCR_AUX_OUTPUT_TWO = 3;
  localparam int MCR_LOOP = 4;
  localparam int MCR_AFE = 5;
  localparam int LCR_PAR_EN = 3;
  localparam int LCR_STOP2 = 2;
  localparam int LCR_DIVISOR_ACCESS_BIT = 7;
  localparam int IER_RDA = 0;
  localparam int IER_MS = 3;
  localparam int FCR_EN = 0;
  localparam logic [7:0] LCR_RESET = 8'h03;
  localparam logic [15:0] DIV_RESET = 16'h0001;
  localparam logic [3:0] OVERSAMPLE = 4'hf;
  localparam logic [3:0] MID_SAMPLE = 4'h7;
  localparam logic [31:0] SLVERR_NONE = 32'h0;
  typedef enum logic [1:0] {UMS_IDLE, UMS_START, UMS_DATA, UMS_STOP} ums_rx_e;
endpackage

// ### hdl/ums_top.sv
// modem status, baud generator, receiver fifo and scratch register on apb
// Behaviour
// R1 - reading modem status clears the four change flags
// R2 - cts change sets bit 0; interrupt only if enabled and autoflow off
// R3 - dsr change sets bit 1; raises modem interrupt if enabled
// R4 - ring low-to-high sets bit 2; raises modem interrupt if enabled
// R5 - dcd change sets bit 3; raises modem interrupt if enabled
// R6 - bit 4 is inverted cts, or rts control bit in loopback
// R7 - bit 5 is inverted dsr, or dtr control bit in loopback
// R8 - bit 6 is inverted ring, or aux output one in loopback
// R9 - bit 7 is inverted dcd, or aux output two in loopback
// R10 - baud generator divides clock by divisor 1 to 65535
// R11 - generator output is sixteen times the baud rate
// R12 - divisor held in two 8-bit latch registers
// R13 - writing either latch reloads the baud counter at once
// R14 - software programs both latches before relying on timing
// R15 - receive shifter deserializes input into a 16-byte fifo
// R16 - each serial bit spans sixteen receive clock ticks
// R17 - character framing follows the line control register
// R18 - non-fifo mode: character raises data interrupt, reading clears it
// R19 - fifo mode: receive interrupt follows fifo trigger and enable
// R20 - 8-bit scratch register with no other effect
// R21 - divisor access bit selects latches versus shared locations
// R22 - control bit 4 loops control outputs back to modem inputs
// R23 - control bit 5 enables autoflow, masking cts change interrupt
// R24 - a change coinciding with the status read stays set
// R25 - status writes ignored; modem inputs synchronised before edges
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module ums_top #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clock_in, // 125 mhz clock
  input wire logic rst_in, // synchronous reset, active high
  input wire logic psel_in, // apb select
  input wire logic penable_in, // apb enable
  input wire logic pwrite_in, // apb direction
  input wire logic [7:0] paddr_in, // apb byte address
  input wire logic [31:0] pwdata_in, // apb write data
  output logic [31:0] prdata_out, // apb read data
  output logic pready_out, // apb ready
  output logic pslverr_out, // apb error, unmapped address
  input wire logic serial_input_in, // serial data pin
  input wire logic cts_n_in, // clear to send, active low
  input wire logic dsr_n_in, // data set ready, active low
  input wire logic ri_n_in, // ring indicator, active low
  input wire logic dcd_n_in, // carrier detect, active low
  output logic dtr_n_out, // terminal ready, active low
  output logic rts_n_out, // request to send, active low
  output logic baud_tick_out, // 16x receive clock pulse
  output logic irq_out // modem or receive interrupt, active high
);
  localparam int AW = $clog2(FIFO_DEPTH);
  initial begin
    if (FIFO_DEPTH != 16) $error("fifo depth must be 16");
  end

  // two-flop synchronisers on the serial and modem input pins
  logic [4:0] sync1_q, sync1_d, sync2_q, sync2_d;
  logic [4:0] pin_raw;
  assign pin_raw = {serial_input_in, dcd_n_in, ri_n_in, dsr_n_in, cts_n_in};

  // register state
  logic [7:0] lcr_q, lcr_d, mcr_q, mcr_d, ier_q, ier_d, fcr_q, fcr_d, scr_q, scr_d;
  logic [15:0] div_q, div_d, cnt_q, cnt_d;
  logic [3:0] delta_q, delta_d;
  logic [3:0] prev_q, prev_d;
  logic tick_q, tick_d;
  logic [31:0] rdata_q, rdata_d;
  logic ready_q, ready_d, err_q, err_d, irq_q, irq_d;
  logic [7:0] mem_q [FIFO_DEPTH];
  logic [AW:0] count_q, count_d;
  logic [AW-1:0] rd_q, rd_d, wr_q, wr_d;
  logic oe_q, oe_d;
  // receiver
  ums_pkg::ums_rx_e st_q, st_d;
  logic [3:0] sub_q, sub_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic push;

  logic acc, wr_acc, rd_acc, mapped;
  logic [3:0] live; // active-high modem state: cts, dsr, ri, dcd
  logic [3:0] msr_hi;
  logic sin_eff;
  logic [3:0] data_bits;
  logic [7:0] rx_byte;
  logic [AW:0] trig;
  logic rx_irq, ms_irq;

  assign acc = psel_in && penable_in && !ready_q;
  assign wr_acc = acc && pwrite_in;
  assign rd_acc = acc && !pwrite_in;
  assign mapped = paddr_in <= ums_pkg::ADDR_IRQ && paddr_in[1:0] == 2'b00;

  always_comb begin
    // R22 loop routes controls internally
    if (mcr_q[ums_pkg::MCR_LOOP]) begin
      live = {mcr_q[ums_pkg::MCR_AUX_OUTPUT_TWO], mcr_q[ums_pkg::MCR_AUX_OUTPUT_ONE],
              mcr_q[ums_pkg::MCR_DTR], mcr_q[ums_pkg::MCR_RTS]};
      sin_eff = 1'b1;
    end else begin
      live = ~sync2_q[3:0];
      sin_eff = sync2_q[4];
    end
  end
  // R6 R7 R8 R9 status high nibble is cts, dsr, ri, dcd
  assign msr_hi = live;

  // R17 data bits from lcr word length
  assign data_bits = 4'h5 + {2'b00, lcr_q[1:0]};
  always_comb begin
    rx_byte = sh_q >> (4'h8 - data_bits);
  end

  always_comb begin
    case (fcr_q[7:6])
      2'b00: trig = (AW+1)'(1);
      2'b01: trig = (AW+1)'(4);
      2'b10: trig = (AW+1)'(8);
      default: trig = (AW+1)'(14);
    endcase
  end

  always_comb begin
    sync1_d = pin_raw;
    sync2_d = sync1_q;
    prev_d = live;
    delta_d = delta_q;
    // R1 read clears change flags
    if (rd_acc && paddr_in == ums_pkg::ADDR_MSR) delta_d = 4'h0;
    // R24 set wins over clear; R25 edges on synced inputs
    // R2 cts change
    if (live[0] != prev_q[0]) delta_d[0] = 1'b1;
    // R3 dsr change
    if (live[1] != prev_q[1]) delta_d[1] = 1'b1;
    // R4 ring trailing edge: pin low-to-high means asserted state ends
    if (!live[2] && prev_q[2]) delta_d[2] = 1'b1;
    // R5 carrier change
    if (live[3] != prev_q[3]) delta_d[3] = 1'b1;
  end

  // R12 R20 R21 R25 register writes
  always_comb begin
    lcr_d = lcr_q;
    mcr_d = mcr_q;
    ier_d = ier_q;
    fcr_d = fcr_q;
    scr_d = scr_q;
    div_d = div_q;
    if (wr_acc) begin
      case (paddr_in)
        ums_pkg::ADDR_RXBUF_DLL: if (lcr_q[ums_pkg::LCR_DIVISOR_ACCESS_BIT]) div_d[7:0] = pwdata_in[7:0];
        ums_pkg::ADDR_IER_DLM: begin
          if (lcr_q[ums_pkg::LCR_DIVISOR_ACCESS_BIT]) div_d[15:8] = pwdata_in[7:0];
          else ier_d = pwdata_in[7:0];
        end
        ums_pkg::ADDR_FCR: fcr_d = pwdata_in[7:0];
        ums_pkg::ADDR_LCR: lcr_d = pwdata_in[7:0];
        ums_pkg::ADDR_MCR: mcr_d = {2'b00, pwdata_in[5:0]};
        ums_pkg::ADDR_SCR: scr_d = pwdata_in[7:0];
        default: ;
      endcase
    end
  end

  logic div_wr;
  assign div_wr = wr_acc && lcr_q[ums_pkg::LCR_DIVISOR_ACCESS_BIT] &&
                  (paddr_in == ums_pkg::ADDR_RXBUF_DLL || paddr_in == ums_pkg::ADDR_IER_DLM);

  // R10 R11 R13 baud divider, reloaded by latch writes
  always_comb begin
    tick_d = 1'b0;
    cnt_d = cnt_q - 16'h0001;
    if (div_wr) begin
      cnt_d = (paddr_in == ums_pkg::ADDR_RXBUF_DLL) ? {div_q[15:8], pwdata_in[7:0]}
                                                    : {pwdata_in[7:0], div_q[7:0]};
    end else if (cnt_q <= 16'h0001) begin
      cnt_d = div_q;
      tick_d = 1'b1;
    end
  end

  // R15 R16 R17 receiver, sampling mid-bit every 16 ticks
  always_comb begin
    st_d = st_q;
    sub_d = sub_q;
    bit_d = bit_q;
    sh_d = sh_q;
    push = 1'b0;
    if (tick_q) begin
      case (st_q)
        ums_pkg::UMS_IDLE: if (!sin_eff) begin
          st_d = ums_pkg::UMS_START;
          sub_d = 4'h0;
        end
        ums_pkg::UMS_START: begin
          sub_d = sub_q + 4'h1;
          if (sub_q == ums_pkg::MID_SAMPLE) begin
            // false start rejected
            if (sin_eff) st_d = ums_pkg::UMS_IDLE;
            sub_d = 4'h0;
            bit_d = 4'h0;
            if (!sin_eff) st_d = ums_pkg::UMS_DATA;
          end
        end
        ums_pkg::UMS_DATA: begin
          sub_d = sub_q + 4'h1;
          if (sub_q == ums_pkg::OVERSAMPLE) begin
            // parity bit is sampled but never shifted, so data bit 0 survives
            if (bit_q < data_bits) sh_d = {sin_eff, sh_q[7:1]};
            bit_d = bit_q + 4'h1;
            if (bit_q + 4'h1 == data_bits + {3'b000, lcr_q[ums_pkg::LCR_PAR_EN]})
              st_d = ums_pkg::UMS_STOP;
          end
        end
        ums_pkg::UMS_STOP: begin
          sub_d = sub_q + 4'h1;
          if (sub_q == ums_pkg::OVERSAMPLE) begin
            push = 1'b1;
            st_d = ums_pkg::UMS_IDLE;
          end
        end
        default: st_d = ums_pkg::UMS_IDLE;
      endcase
    end
  end

  // parity bit never enters the shifter, so the character is the aligned byte
  logic [7:0] rx_char;
  assign rx_char = rx_byte;

  logic pop;
  assign pop = rd_acc && paddr_in == ums_pkg::ADDR_RXBUF_DLL &&
               !lcr_q[ums_pkg::LCR_DIVISOR_ACCESS_BIT] && count_q != '0;

  // R15 receive fifo; non-fifo mode keeps one entry
  logic [AW:0] cap;
  assign cap = fcr_q[ums_pkg::FCR_EN] ? (AW+1)'(FIFO_DEPTH) : (AW+1)'(1);
  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    count_d = count_q;
    oe_d = oe_q;
    if (rd_acc && paddr_in == ums_pkg::ADDR_LSR) oe_d = 1'b0;
    if (pop) begin
      rd_d = rd_q + 1'b1;
      count_d = count_d - 1'b1;
    end
    if (push) begin
      if (count_q < cap || pop) begin
        wr_d = wr_q + 1'b1;
        count_d = count_d + 1'b1;
      end else begin
        oe_d = 1'b1;
      end
    end
    // fifo enable change flushes
    if (wr_acc && paddr_in == ums_pkg::ADDR_FCR &&
        pwdata_in[ums_pkg::FCR_EN] != fcr_q[ums_pkg::FCR_EN]) begin
      wr_d = '0;
      rd_d = '0;
      count_d = '0;
    end
  end

  // R18 R19 receive interrupt: one char, or fifo trigger level
  assign rx_irq = ier_q[ums_pkg::IER_RDA] &&
                  (fcr_q[ums_pkg::FCR_EN] ? count_q >= trig : count_q != '0);
  // R2 R23 cts change masked under autoflow
  assign ms_irq = ier_q[ums_pkg::IER_MS] &&
                  ((delta_q[0] && !mcr_q[ums_pkg::MCR_AFE]) || |delta_q[3:1]);

  always_comb begin
    irq_d = rx_irq || ms_irq;
    ready_d = psel_in && penable_in && !ready_q;
    err_d = acc && !mapped;
    rdata_d = 32'h0;
    if (rd_acc) begin
      case (paddr_in)
        ums_pkg::ADDR_RXBUF_DLL: rdata_d[7:0] = lcr_q[ums_pkg::LCR_DIVISOR_ACCESS_BIT] ? div_q[7:0]
                                                                       : mem_q[rd_q];
        ums_pkg::ADDR_IER_DLM: rdata_d[7:0] = lcr_q[ums_pkg::LCR_DIVISOR_ACCESS_BIT] ? div_q[15:8] : ier_q;
        ums_pkg::ADDR_FCR: rdata_d[7:0] = fcr_q;
        ums_pkg::ADDR_LCR: rdata_d[7:0] = lcr_q;
        ums_pkg::ADDR_MCR: rdata_d[7:0] = mcr_q;
        ums_pkg::ADDR_LSR: rdata_d[7:0] = {6'h0, oe_q, count_q != '0};
        ums_pkg::ADDR_MSR: rdata_d[7:0] = {msr_hi[3], msr_hi[2], msr_hi[1], msr_hi[0], delta_q};
        ums_pkg::ADDR_SCR: rdata_d[7:0] = scr_q;
        ums_pkg::ADDR_IRQ: rdata_d[7:0] = {6'h0, ms_irq, rx_irq};
        default: rdata_d = ums_pkg::SLVERR_NONE;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (push && (count_q < cap || pop)) mem_q[wr_q] <= rx_char;
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sync1_q <= 5'h1f;
      sync2_q <= 5'h1f;
      prev_q <= 4'h0;
      delta_q <= 4'h0;
      lcr_q <= ums_pkg::LCR_RESET;
      mcr_q <= 8'h00;
      ier_q <= 8'h00;
      fcr_q <= 8'h00;
      scr_q <= 8'h00;
      div_q <= ums_pkg::DIV_RESET;
      cnt_q <= ums_pkg::DIV_RESET;
      tick_q <= 1'b0;
      st_q <= ums_pkg::UMS_IDLE;
      sub_q <= 4'h0;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
      oe_q <= 1'b0;
      rdata_q <= 32'h0;
      ready_q <= 1'b0;
      err_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      prev_q <= prev_d;
      delta_q <= delta_d;
      lcr_q <= lcr_d;
      mcr_q <= mcr_d;
      ier_q <= ier_d;
      fcr_q <= fcr_d;
      scr_q <= scr_d;
      div_q <= div_d;
      cnt_q <= cnt_d;
      tick_q <= tick_d;
      st_q <= st_d;
      sub_q <= sub_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      count_q <= count_d;
      oe_q <= oe_d;
      rdata_q <= rdata_d;
      ready_q <= ready_d;
      err_q <= err_d;
      irq_q <= irq_d;
    end
  end

  assign prdata_out = rdata_q;
  assign pready_out = ready_q;
  assign pslverr_out = err_q;
  assign irq_out = irq_q;
  assign baud_tick_out = tick_q;
  // loopback forces the control outputs inactive
  assign dtr_n_out = ~(mcr_q[ums_pkg::MCR_DTR] & ~mcr_q[ums_pkg::MCR_LOOP]);
  assign rts_n_out = ~(mcr_q[ums_pkg::MCR_RTS] & ~mcr_q[ums_pkg::MCR_LOOP]);

  // assertions
  property p_msr_clear;
    @(posedge clock_in) disable iff (rst_in)
      (rd_acc && paddr_in == ums_pkg::ADDR_MSR && live == prev_q) |=> delta_q == 4'h0;
  endproperty
  a_msr_clear: assert property (p_msr_clear) else $error("change flags not cleared"); // R1
  property p_cts_set;
    @(posedge clock_in) disable iff (rst_in) (live[0] != prev_q[0]) |=> delta_q[0];
  endproperty
  a_cts_set: assert property (p_cts_set) else $error("cts change lost"); // R2
  property p_dsr_set;
    @(posedge clock_in) disable iff (rst_in) (live[1] != prev_q[1]) |=> delta_q[1];
  endproperty
  a_dsr_set: assert property (p_dsr_set) else $error("dsr change lost"); // R3
  property p_ri_edge;
    @(posedge clock_in) disable iff (rst_in)
      ($rose(delta_q[2])) |-> ($past(prev_q[2]) && !$past(live[2]));
  endproperty
  a_ri_edge: assert property (p_ri_edge) else $error("ring flag without trailing edge"); // R4
  property p_dcd_set;
    @(posedge clock_in) disable iff (rst_in) (live[3] != prev_q[3]) |=> delta_q[3];
  endproperty
  a_dcd_set: assert property (p_dcd_set) else $error("dcd change lost"); // R5
  property p_loop_cts;
    @(posedge clock_in) disable iff (rst_in)
      mcr_q[ums_pkg::MCR_LOOP] |-> msr_hi[0] == mcr_q[ums_pkg::MCR_RTS];
  endproperty
  a_loop_cts: assert property (p_loop_cts) else $error("loop cts mismatch"); // R6
  property p_afe_mask;
    @(posedge clock_in) disable iff (rst_in)
      (mcr_q[ums_pkg::MCR_AFE] && delta_q == 4'h1 && !rx_irq) |=> !irq_q;
  endproperty
  a_afe_mask: assert property (p_afe_mask) else $error("cts irq under autoflow"); // R23
  property p_reload;
    @(posedge clock_in) disable iff (rst_in) div_wr |=> !tick_q;
  endproperty
  a_reload: assert property (p_reload) else $error("counter not reloaded"); // R13
  property p_tick_period;
    @(posedge clock_in) disable iff (rst_in)
      (tick_q && div_q == 16'h0002 && $stable(div_q)) |=> !tick_q ##1 tick_q;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("divide by two wrong"); // R10
  property p_ready;
    @(posedge clock_in) disable iff (rst_in) acc |=> ready_q ##1 !ready_q;
  endproperty
  a_ready: assert property (p_ready) else $error("apb ready not one cycle");
  c_rx_push: cover property (@(posedge clock_in) disable iff (rst_in) push);
  c_msr_irq: cover property (@(posedge clock_in) disable iff (rst_in) ms_irq ##1 irq_q);
  c_loop: cover property (@(posedge clock_in) disable iff (rst_in) mcr_q[ums_pkg::MCR_LOOP]);
endmodule
`default_nettype wire

// ### verif/ums_modem_model.sv
// far-side modem model: serial line and modem control pins
`timescale 1ns/1ns
`default_nettype none
module ums_modem_model (
  input wire logic clock_in, // device clock
  input wire logic tick_in, // 16x tick from the device
  output logic serial_out, // serial line, idle high
  output logic [3:0] pins_n_out // dcd, ri, dsr, cts from msb, active low
);
  initial begin
    serial_out = 1'b1;
    pins_n_out = 4'hf;
  end
  task automatic set_pins(input logic [3:0] lvl_n);
    @(posedge clock_in);
    pins_n_out <= lvl_n;
  endtask
  task automatic wait_bit();
    int n;
    for (int k = 0; k < 16; k++) begin
      n = 0;
      do begin
        @(posedge clock_in);
        n++;
      end while (tick_in !== 1'b1 && n < 70000);
    end
  endtask
  // start, data lsb first, optional parity, stop
  task automatic send_char(input logic [7:0] data, input int nbits, input int par);
    @(posedge clock_in);
    for (int i = -1; i <= nbits + par; i++) begin
      serial_out <= (i < 0) ? 1'b0 : (i == nbits + par) ? 1'b1 : (i < nbits) ? data[i] : 1'b0;
      wait_bit();
    end
  endtask
endmodule
`default_nettype wire

// ### verif/testbench.sv
// self-checking bench for the modem status, baud and receive block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clock_in, rst_in, psel, penable, pwrite, pready, pslverr, serial, dtr_n, rts_n, tick, irq;
  logic [7:0] paddr, rd;
  logic [31:0] pwdata, prdata;
  logic [3:0] pins_n;
  logic err;
  int mismatches, checked, w, g;
  ums_top i_ums_top (.clock_in(clock_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .serial_input_in(serial), .cts_n_in(pins_n[0]),
    .dsr_n_in(pins_n[1]), .ri_n_in(pins_n[2]), .dcd_n_in(pins_n[3]), .dtr_n_out(dtr_n),
    .rts_n_out(rts_n), .baud_tick_out(tick), .irq_out(irq));
  ums_modem_model i_ums_modem_model (.clock_in(clock_in), .tick_in(tick), .serial_out(serial),
    .pins_n_out(pins_n));
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  task automatic end_sim();
    if (mismatches == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: bit %b, wanted %b", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  // one apb transfer; waits for ready under a bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clock_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'hffffff, d};
    @(posedge clock_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      mismatches++;
      $display("unexpected at %0t: no ready", $time);
      end_sim();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk_byte(rd, exp);
  endtask
  // w: cycles until a tick, g: cycles between two ticks
  task automatic tick_gap();
    w = 0;
    while (tick !== 1'b1 && w < 100) begin
      @(posedge clock_in);
      w++;
    end
    @(posedge clock_in);
    g = 1;
    while (tick !== 1'b1 && g < 100) begin
      @(posedge clock_in);
      g++;
    end
  endtask
  initial begin
    rst_in = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    cyc(5);
    rst_in <= 1'b0;
    cyc(4);
    wr(ums_pkg::ADDR_SCR, 8'ha5);
    rc(ums_pkg::ADDR_SCR, 8'ha5);
    rc(ums_pkg::ADDR_MSR, 8'h00);
    wr(ums_pkg::ADDR_MSR, 8'hff);
    rc(ums_pkg::ADDR_MSR, 8'h00);
    apb(1'b0, 8'h40, 8'h00);
    chk_bit(err, 1'b1);
    // ring asserting gives no flag, only its release does
    for (int i = 0; i < 4; i++) begin
      i_ums_modem_model.set_pins(4'hf ^ (4'h1 << i));
      cyc(5);
      rc(ums_pkg::ADDR_MSR, (8'h10 << i) | ((i == 2) ? 8'h00 : (8'h01 << i)));
      rc(ums_pkg::ADDR_MSR, 8'h10 << i);
      i_ums_modem_model.set_pins(4'hf);
      cyc(5);
      rc(ums_pkg::ADDR_MSR, 8'h01 << i);
    end
    wr(ums_pkg::ADDR_IER_DLM, 8'h08);
    i_ums_modem_model.set_pins(4'hd);
    cyc(5);
    chk_bit(irq, 1'b1);
    rc(ums_pkg::ADDR_MSR, 8'h22);
    cyc(3);
    chk_bit(irq, 1'b0);
    wr(ums_pkg::ADDR_MCR, 8'h20);
    i_ums_modem_model.set_pins(4'hc);
    cyc(5);
    chk_bit(irq, 1'b0);
    rc(ums_pkg::ADDR_MSR, 8'h31);
    wr(ums_pkg::ADDR_MCR, 8'h00);
    i_ums_modem_model.set_pins(4'hf);
    cyc(5);
    chk_bit(irq, 1'b1);
    rc(ums_pkg::ADDR_MSR, 8'h03);
    wr(ums_pkg::ADDR_IER_DLM, 8'h00);
    wr(ums_pkg::ADDR_MCR, 8'h1f);
    cyc(5);
    chk_bit(dtr_n, 1'b1);
    chk_bit(rts_n, 1'b1);
    apb(1'b0, ums_pkg::ADDR_MSR, 8'h00);
    rc(ums_pkg::ADDR_MSR, 8'hf0);
    wr(ums_pkg::ADDR_MCR, 8'h13);
    i_ums_modem_model.set_pins(4'h0);
    cyc(5);
    rc(ums_pkg::ADDR_MSR, 8'h3c);
    i_ums_modem_model.set_pins(4'hf);
    wr(ums_pkg::ADDR_MCR, 8'h00);
    cyc(5);
    apb(1'b0, ums_pkg::ADDR_MSR, 8'h00);
    wr(ums_pkg::ADDR_LCR, 8'h83);
    wr(ums_pkg::ADDR_IER_DLM, 8'hff);
    wr(ums_pkg::ADDR_RXBUF_DLL, 8'h03);
    wr(ums_pkg::ADDR_IER_DLM, 8'h00);
    tick_gap();
    chk_bit(w < 8, 1'b1);
    chk_byte(g[7:0], 8'h03);
    rc(ums_pkg::ADDR_RXBUF_DLL, 8'h03);
    rc(ums_pkg::ADDR_IER_DLM, 8'h00);
    wr(ums_pkg::ADDR_RXBUF_DLL, 8'h02);
    wr(ums_pkg::ADDR_LCR, 8'h03);
    wr(ums_pkg::ADDR_IER_DLM, 8'h01);
    i_ums_modem_model.send_char(8'h5a, 8, 0);
    cyc(8);
    chk_bit(irq, 1'b1);
    rc(ums_pkg::ADDR_RXBUF_DLL, 8'h5a);
    cyc(3);
    chk_bit(irq, 1'b0);
    wr(ums_pkg::ADDR_LCR, 8'h00);
    i_ums_modem_model.send_char(8'h15, 5, 0);
    cyc(8);
    rc(ums_pkg::ADDR_RXBUF_DLL, 8'h15);
    wr(ums_pkg::ADDR_LCR, 8'h0b);
    i_ums_modem_model.send_char(8'hc3, 8, 1);
    cyc(8);
    rc(ums_pkg::ADDR_RXBUF_DLL, 8'hc3);
    wr(ums_pkg::ADDR_LCR, 8'h03);
    wr(ums_pkg::ADDR_FCR, 8'h01);
    // fill all sixteen places before reading any back
    for (int i = 0; i < 16; i++) begin
      i_ums_modem_model.send_char(8'h30 + 8'(i), 8, 0);
    end
    cyc(8);
    chk_bit(irq, 1'b1);
    for (int i = 0; i < 16; i++) begin
      rc(ums_pkg::ADDR_RXBUF_DLL, 8'h30 + 8'(i));
    end
    cyc(3);
    chk_bit(irq, 1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
